// ===== custom_advance_map_editor.sv
// Operation
// - keep five editable maps of four speed and angle pairs
// - speed0 of every map is fixed at zero, never offered
// - speeds held in 100 rpm steps, angles in 1 degree steps
// - speeds inside a map strictly increase
// - editable speeds stay below 30000 rpm
// - all angles stay below 39 degrees
// - at power-up and factory reload maps 10..14 copy preset map 1
// - running values of a map update only when it is selected again
// - offer map numbers every three seconds, switch picks the shown one
// - play back n0 w0 n1 w1 n2 w2 n3 w3
// - speeds shown as successive two-digit groups
// - switch during angle playback skips to the input phase
// - show ready indication before offering parameters
// - offer w0 n1 w1 n2 w2 n3 w3 every three seconds, switch picks one
// - angle tens candidates 0..3 every three seconds, switch latches
// - units candidates 0..9 every three seconds, switch latches
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
module custom_advance_map_editor
  import map_editor_pkg::*;
#(
  parameter int unsigned DWELL_CYCLES = DWELL_CYC
)(
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_arst_n,
  // axi4-lite write
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  // axi4-lite read
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  // operator side
  input  wire logic        i_magnet_sw,
  output logic [4:0]       o_disp_hi,
  output logic [4:0]       o_disp_lo
);

  function automatic logic [8:0] div10(input logic [8:0] v);
    logic [17:0] p;
    p = {9'h000, v} * 18'h000CD;
    return {2'h0, p[17:11]};
  endfunction

  function automatic logic [3:0] mod10(input logic [8:0] v);
    logic [8:0] q;
    logic [8:0] r;
    q = div10(v);
    r = v - ((q << 3) + (q << 1));
    return r[3:0];
  endfunction

  function automatic logic [ADDR_W-1:0] word_addr(input logic [2:0] m,
                                                  input logic [2:0] w);
    return {m, w};
  endfunction

  map_store_if mem ();

  edit_state_e       state_r;
  logic [2:0]        map_sel_r;
  logic [2:0]        idx_r;
  logic              grp_r;
  logic [1:0]        stage_r;
  logic [3:0]        cand_r;
  logic [8:0]        acc_r;
  logic [3:0]        load_cnt_r;
  logic [8:0]        shadow_r [N_WORDS];
  logic [8:0]        run_r [N_WORDS];
  logic              accept_r;
  logic              reject_r;
  logic              restart_r;
  logic [31:0]       dwell_cnt_r;
  logic              dwell_tick;
  logic              sw_s1_r, sw_s2_r, sw_s3_r, sw_stable_r, sw_prev_r;
  logic              actuate;
  logic [3:0]        select_r;
  logic              commit_pend_r;
  logic              enter_pend_r;
  logic              factory_r;
  logic              aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
  logic [7:0]        aw_addr_r;
  logic [31:0]       w_data_r;
  logic [3:0]        w_strb_r;
  logic [1:0]        bresp_r, rresp_r;
  logic [31:0]       rdata_r;
  logic              wr_fire, wr_ctrl, wr_sel, wr_ok;
  logic [2:0]        commit_slot;
  logic [3:0]        cand_max;
  logic [1:0]        last_stage;
  logic [8:0]        acc_nxt;
  logic              value_ok;
  logic [31:0]       rd_word;
  logic              rd_hit;

  map_store map_store_inst (
    .i_clk_sys (i_clk_sys),
    .i_arst_n  (i_arst_n),
    .mem       (mem.store)
  );

  // magnet input: three flops, change taken once the last two agree
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      {sw_s1_r, sw_s2_r, sw_s3_r, sw_stable_r, sw_prev_r} <= 5'h00;
    end else begin
      sw_s1_r   <= i_magnet_sw;
      sw_s2_r   <= sw_s1_r;
      sw_s3_r   <= sw_s2_r;
      sw_prev_r <= sw_stable_r;
      if (sw_s2_r == sw_s3_r) begin
        sw_stable_r <= sw_s3_r;
      end
    end
  end
  assign actuate = sw_stable_r & ~sw_prev_r;

  // each offered item stands one dwell; an actuation restarts the period
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dwell_cnt_r <= '0;
    end else if (restart_r || actuate || dwell_tick) begin
      dwell_cnt_r <= '0;
    end else begin
      dwell_cnt_r <= dwell_cnt_r + 32'h0000_0001;
    end
  end
  assign dwell_tick = (dwell_cnt_r == 32'(DWELL_CYCLES - 1)) && !restart_r;

  assign cand_max   = (stage_r != 2'h0) ? DIGIT_MAX :
                      (idx_r[0] ? ANGLE_TENS_MAX : SPEED_TOP_MAX);
  assign last_stage = idx_r[0] ? ANGLE_LAST_STG : SPEED_LAST_STG;
  assign acc_nxt    = ((acc_r << 3) + (acc_r << 1)) + {5'h00, cand_r};

  always_comb begin
    if (idx_r[0]) begin
      value_ok = acc_r < ANGLE_LIMIT;
    end else begin
      value_ok = (acc_r < SPEED_LIMIT) &&
                 (acc_r > shadow_r[idx_r - 3'h2]) &&
                 ((idx_r == 3'h6) || (acc_r < shadow_r[idx_r + 3'h2]));
    end
  end

  assign commit_slot = 3'(select_r - FIRST_MAP);
  assign mem.raddr   = word_addr((state_r == ST_COMMIT) ? commit_slot
                                 : map_sel_r, load_cnt_r[2:0]);
  assign mem.we      = (state_r == ST_CHECK) && value_ok;
  assign mem.waddr   = word_addr(map_sel_r, idx_r);
  assign mem.wdata   = acc_r;
  assign mem.init    = factory_r;

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r    <= ST_IDLE;
      map_sel_r  <= '0;
      idx_r      <= '0;
      grp_r      <= 1'b0;
      stage_r    <= '0;
      cand_r     <= '0;
      acc_r      <= '0;
      load_cnt_r <= '0;
      accept_r   <= 1'b0;
      reject_r   <= 1'b0;
      restart_r  <= 1'b0;
      for (int i = 0; i < N_WORDS; i++) begin
        shadow_r[i] <= '0;
        run_r[i]    <= INIT_WORD[i];
      end
    end else begin
      restart_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          load_cnt_r <= '0;
          if (commit_pend_r) begin
            state_r <= ST_COMMIT;
          end else if (enter_pend_r) begin
            state_r   <= ST_BANNER;
            restart_r <= 1'b1;
          end
        end
        ST_BANNER: begin
          if (dwell_tick) begin
            state_r   <= ST_PICK_MAP;
            map_sel_r <= '0;
          end
        end
        ST_PICK_MAP: begin
          if (actuate) begin
            state_r <= ST_LOAD;
          end else if (dwell_tick) begin
            map_sel_r <= (map_sel_r == LAST_SLOT) ? 3'h0 : map_sel_r + 3'h1;
          end
        end
        ST_LOAD: begin
          load_cnt_r <= load_cnt_r + 4'h1;
          if (load_cnt_r != 4'h0) begin
            shadow_r[3'(load_cnt_r - 4'h1)] <= mem.rdata;
          end
          if (load_cnt_r == LOAD_DONE) begin
            state_r   <= ST_PLAY;
            idx_r     <= '0;
            grp_r     <= 1'b0;
            restart_r <= 1'b1;
          end
        end
        ST_PLAY: begin
          if (actuate && idx_r[0]) begin
            state_r <= ST_READY;
          end else if (dwell_tick) begin
            if (!idx_r[0] && !grp_r) begin
              grp_r <= 1'b1;
            end else begin
              grp_r <= 1'b0;
              if (idx_r == LAST_WORD) begin
                state_r <= ST_READY;
              end else begin
                idx_r <= idx_r + 3'h1;
              end
            end
          end
        end
        ST_READY: begin
          if (dwell_tick) begin
            state_r <= ST_PICK_PARAM;
            idx_r   <= FIRST_EDIT;
          end
        end
        ST_PICK_PARAM: begin
          if (actuate) begin
            state_r <= ST_DIGIT;
            stage_r <= '0;
            cand_r  <= '0;
            acc_r   <= '0;
          end else if (dwell_tick) begin
            idx_r <= (idx_r == LAST_WORD) ? FIRST_EDIT : idx_r + 3'h1;
          end
        end
        ST_DIGIT: begin
          if (actuate) begin
            acc_r  <= acc_nxt;
            cand_r <= '0;
            if (stage_r == last_stage) begin
              state_r <= ST_CHECK;
            end else begin
              stage_r <= stage_r + 2'h1;
            end
          end else if (dwell_tick) begin
            cand_r <= (cand_r == cand_max) ? 4'h0 : cand_r + 4'h1;
          end
        end
        ST_CHECK: begin
          state_r  <= ST_IDLE;
          accept_r <= value_ok;
          reject_r <= !value_ok;
          if (value_ok) begin
            shadow_r[idx_r] <= acc_r;
          end
        end
        ST_COMMIT: begin
          load_cnt_r <= load_cnt_r + 4'h1;
          if (load_cnt_r != 4'h0) begin
            run_r[3'(load_cnt_r - 4'h1)] <= mem.rdata;
          end
          if (load_cnt_r == LOAD_DONE) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // display characters come from flops
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_disp_hi <= CH_BLANK;
      o_disp_lo <= CH_BLANK;
    end else begin
      o_disp_hi <= CH_BLANK;
      o_disp_lo <= CH_BLANK;
      case (state_r)
        ST_BANNER: begin
          o_disp_hi <= CH_BIG_C; // custom_map_menu_indication
          o_disp_lo <= CH_SMALL_C;
        end
        ST_PICK_MAP: begin
          o_disp_hi <= {1'b0, mod10({5'h00, FIRST_MAP} / 9'h00A)};
          o_disp_lo <= {2'h0, map_sel_r};
        end
        ST_PLAY: begin
          if (idx_r[0]) begin
            o_disp_hi <= {1'b0, mod10(div10(shadow_r[idx_r]))};
            o_disp_lo <= {1'b0, mod10(shadow_r[idx_r])};
          end else if (!grp_r) begin
            o_disp_hi <= {1'b0, mod10(div10(div10(shadow_r[idx_r])))};
            o_disp_lo <= {1'b0, mod10(div10(shadow_r[idx_r]))};
          end else begin
            o_disp_hi <= {1'b0, mod10(shadow_r[idx_r])};
            o_disp_lo <= 5'h00;
          end
        end
        ST_READY: begin
          o_disp_hi <= CH_I;
          o_disp_lo <= CH_I;
        end
        ST_PICK_PARAM: begin
          o_disp_hi <= idx_r[0] ? CH_W : CH_N;
          o_disp_lo <= {3'h0, idx_r[2:1]};
        end
        ST_DIGIT: begin
          o_disp_hi <= {3'h0, stage_r};
          o_disp_lo <= {1'b0, cand_r};
        end
        default: ;
      endcase
    end
  end

  // axi4-lite slave, one write and one read in flight
  assign o_awready = !aw_hold_r && !bvalid_r;
  assign o_wready  = !w_hold_r && !bvalid_r;
  assign o_arready = !rvalid_r;
  assign o_bvalid  = bvalid_r;
  assign o_bresp   = bresp_r;
  assign o_rvalid  = rvalid_r;
  assign o_rresp   = rresp_r;
  assign o_rdata   = rdata_r;
  assign wr_fire   = aw_hold_r && w_hold_r && !bvalid_r;
  assign wr_ok     = (aw_addr_r == REG_CTRL) || (aw_addr_r == REG_SELECT);
  assign wr_ctrl   = wr_fire && (aw_addr_r == REG_CTRL) && w_strb_r[0];
  assign wr_sel    = wr_fire && (aw_addr_r == REG_SELECT) && w_strb_r[0];

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      aw_addr_r <= '0;
      w_data_r  <= '0;
      w_strb_r  <= '0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= i_wdata;
        w_strb_r <= i_wstrb;
      end
      if (wr_fire) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_ok ? RESP_OKAY : RESP_DECERR;
      end else if (bvalid_r && i_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // a request arriving while its flag is being consumed is kept
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      select_r      <= FIRST_MAP;
      commit_pend_r <= 1'b0;
      enter_pend_r  <= 1'b0;
      factory_r     <= 1'b0;
    end else begin
      factory_r <= wr_ctrl && w_data_r[CTRL_FACTORY_BIT];
      if (wr_sel) begin
        select_r <= w_data_r[3:0];
      end
      if (wr_sel && (w_data_r[3:0] >= FIRST_MAP) &&
          (w_data_r[3:0] <= LAST_MAP)) begin
        commit_pend_r <= 1'b1;
      end else if (state_r == ST_IDLE) begin
        commit_pend_r <= 1'b0;
      end
      if (wr_ctrl && w_data_r[CTRL_ENTER_BIT]) begin
        enter_pend_r <= 1'b1;
      end else if ((state_r == ST_IDLE) && !commit_pend_r) begin
        enter_pend_r <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_word = '0;
    rd_hit  = 1'b1;
    if (i_araddr == REG_CTRL) begin
      rd_word = '0;
    end else if (i_araddr == REG_SELECT) begin
      rd_word[3:0] = select_r;
    end else if (i_araddr == REG_STATUS) begin
      rd_word[STAT_STATE_LSB +: 4] = state_r;
      rd_word[STAT_MAP_LSB +: 3]   = map_sel_r;
      rd_word[STAT_ACCEPT_BIT]     = accept_r;
      rd_word[STAT_REJECT_BIT]     = reject_r;
      rd_word[STAT_COMMIT_BIT]     = commit_pend_r;
      rd_word[STAT_ENTER_BIT]      = enter_pend_r;
    end else if ((i_araddr & RUN_MASK) == REG_RUN_BASE) begin
      rd_word[8:0] = run_r[i_araddr[4:2]];
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_word;
      rresp_r  <= rd_hit ? RESP_OKAY : RESP_DECERR;
    end else if (rvalid_r && i_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);

  a_angle_limit:
    assert property (mem.we && mem.waddr[0] |-> mem.wdata < ANGLE_LIMIT)
    else $error("angle above limit written");
  a_speed_limit:
    assert property (mem.we && !mem.waddr[0] |-> mem.wdata < SPEED_LIMIT)
    else $error("speed above limit written");
  a_speed_order:
    assert property (mem.we && !mem.waddr[0] |->
                     mem.wdata > shadow_r[idx_r - 3'h2])
    else $error("speed not above previous point");
  a_speed0_fixed:
    assert property (mem.we |-> mem.waddr[2:0] != 3'h0)
    else $error("speed0 written");
  a_tens_range:
    assert property (state_r == ST_DIGIT && idx_r[0] && stage_r == 2'h0
                     |-> cand_r <= ANGLE_TENS_MAX)
    else $error("angle tens candidate out of range");
  a_units_range:
    assert property (state_r == ST_DIGIT |-> cand_r <= DIGIT_MAX)
    else $error("digit candidate out of range");
  a_ready_first:
    assert property (state_r == ST_PICK_PARAM && $past(state_r) != state_r
                     |-> $past(state_r) == ST_READY)
    else $error("parameters offered without ready indication");
  a_angle_cut:
    assert property (state_r == ST_PLAY && idx_r[0] && actuate
                     |=> state_r == ST_READY ##1 o_disp_hi == CH_I)
    else $error("angle playback not cut short");
  a_reject_keep:
    assert property (state_r == ST_CHECK && !value_ok
                     |-> !mem.we ##1 reject_r && state_r == ST_IDLE &&
                         $stable(shadow_r[idx_r]))
    else $error("bad entry not rejected");
  a_map_pick:
    assert property (state_r == ST_PICK_MAP && actuate
                     |=> state_r == ST_LOAD && $stable(map_sel_r))
    else $error("map pick not taken");

endmodule

// ===== map_editor_pkg.sv
package map_editor_pkg;

  // storage geometry
  localparam int          N_MAPS      = 5;
  localparam int          N_WORDS     = 8;
  localparam int          N_STORE     = N_MAPS * N_WORDS;
  localparam int          WORD_W      = 9;
  localparam int          ADDR_W      = 6;

  // value units: speed in 100 rpm steps, angle in 1 degree steps
  localparam logic [8:0]  SPEED_LIMIT = 9'h12C;
  localparam logic [8:0]  ANGLE_LIMIT = 9'h027;
  localparam logic [3:0]  FIRST_MAP   = 4'hA;
  localparam logic [3:0]  LAST_MAP    = 4'hE;
  localparam logic [2:0]  LAST_SLOT   = 3'h4;
  localparam logic [2:0]  LAST_WORD   = 3'h7;
  localparam logic [2:0]  FIRST_EDIT  = 3'h1;
  localparam logic [3:0]  LOAD_DONE   = 4'h8;

  // power-on contents of every custom map: n0 w0 n1 w1 n2 w2 n3 w3
  localparam logic [8:0]  INIT_WORD [N_WORDS] = '{
    9'h000, 9'h019, 9'h01E, 9'h019, 9'h03C, 9'h01E, 9'h0DC, 9'h019};

  // digit entry
  localparam logic [3:0]  ANGLE_TENS_MAX = 4'h3;
  localparam logic [3:0]  SPEED_TOP_MAX  = 4'h2;
  localparam logic [3:0]  DIGIT_MAX      = 4'h9;
  localparam logic [1:0]  ANGLE_LAST_STG = 2'h1;
  localparam logic [1:0]  SPEED_LAST_STG = 2'h2;

  // dwell time of every offered item
  localparam int unsigned DWELL_TIME_MS = 3000;
  localparam int unsigned CLK_FREQ_KHZ  = 100000;
  localparam int unsigned DWELL_CYC     = DWELL_TIME_MS * CLK_FREQ_KHZ;

  // register map
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_SELECT   = 8'h04;
  localparam logic [7:0]  REG_STATUS   = 8'h08;
  localparam logic [7:0]  REG_RUN_BASE = 8'h20;
  localparam logic [7:0]  RUN_MASK     = 8'hE0;
  localparam int          CTRL_ENTER_BIT  = 0;
  localparam int          CTRL_FACTORY_BIT = 1;
  localparam int          STAT_STATE_LSB  = 0;
  localparam int          STAT_MAP_LSB    = 4;
  localparam int          STAT_ACCEPT_BIT = 8;
  localparam int          STAT_REJECT_BIT = 9;
  localparam int          STAT_COMMIT_BIT = 10;
  localparam int          STAT_ENTER_BIT  = 11;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_DECERR = 2'h3;

  // display characters
  localparam logic [4:0]  CH_BIG_C   = 5'h0A;
  localparam logic [4:0]  CH_SMALL_C = 5'h0B;
  localparam logic [4:0]  CH_I       = 5'h0C;
  localparam logic [4:0]  CH_N       = 5'h0D;
  localparam logic [4:0]  CH_W       = 5'h0E;
  localparam logic [4:0]  CH_BLANK   = 5'h1F;

  typedef enum logic [3:0] {
    ST_IDLE       = 4'h0,
    ST_BANNER     = 4'h1,
    ST_PICK_MAP   = 4'h2,
    ST_LOAD       = 4'h3,
    ST_PLAY       = 4'h4,
    ST_READY      = 4'h5,
    ST_PICK_PARAM = 4'h6,
    ST_DIGIT      = 4'h7,
    ST_CHECK      = 4'h8,
    ST_COMMIT     = 4'h9
  } edit_state_e;

endpackage

// ===== map_store_if.sv
`timescale 1ns/100ps
interface map_store_if;
  import map_editor_pkg::*;
  logic              we;
  logic [ADDR_W-1:0] waddr;
  logic [WORD_W-1:0] wdata;
  logic [ADDR_W-1:0] raddr;
  logic [WORD_W-1:0] rdata;
  logic              init;
  modport ctl   (output we, waddr, wdata, raddr, init, input rdata);
  modport store (input we, waddr, wdata, raddr, init, output rdata);
endinterface

// ===== map_store.sv
`timescale 1ns/100ps
module map_store
  import map_editor_pkg::*;
(
  // clock and reset
  input  wire logic     i_clk_sys,
  input  wire logic     i_arst_n,
  // access port
  map_store_if.store    mem
);

  logic [WORD_W-1:0] words_r [N_STORE];
  logic [WORD_W-1:0] rdata_r;

  // flops rather than a RAM so reset and factory reload fill all maps at once
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int i = 0; i < N_STORE; i++) begin
        words_r[i] <= INIT_WORD[i % N_WORDS];
      end
    end else if (mem.init) begin
      for (int i = 0; i < N_STORE; i++) begin
        words_r[i] <= INIT_WORD[i % N_WORDS];
      end
    end else if (mem.we && (int'(mem.waddr) < N_STORE)) begin
      words_r[mem.waddr] <= mem.wdata;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_r <= '0;
    end else if (int'(mem.raddr) < N_STORE) begin
      rdata_r <= words_r[mem.raddr];
    end else begin
      rdata_r <= '0;
    end
  end

  assign mem.rdata = rdata_r;

endmodule

// ===== magnet_operator.sv
`timescale 1ns/100ps
module magnet_operator (
  // clock
  input  wire logic       i_clk_sys,
  // display watched by the operator
  input  wire logic [4:0] i_disp_hi,
  input  wire logic [4:0] i_disp_lo,
  // magnet switch, idle low
  output logic            o_sw
);
  initial o_sw = 1'b0;

  // waits for an item to come up, then holds the magnet past the filter
  task automatic pick(input logic [4:0] h, l, input bit act, output bit ok);
    int n;
    n = 0;
    // an item already up may be near its end: let it pass first
    while (act && i_disp_hi === h && i_disp_lo === l && n < 4000) begin
      @(negedge i_clk_sys);
      n++;
    end
    while (!(i_disp_hi === h && i_disp_lo === l) && n < 4000) begin
      @(negedge i_clk_sys);
      n++;
    end
    ok = (n < 4000);
    if (act) begin
      @(posedge i_clk_sys);
      o_sw <= 1'b1;
      repeat (6) @(posedge i_clk_sys);
      o_sw <= 1'b0;
    end
  endtask
endmodule

// ===== custom_advance_map_editor_tb.sv
`timescale 1ns/100ps
module custom_advance_map_editor_tb;
  import map_editor_pkg::*;
  logic        clk, rst_n, sw, ok_b;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rs;
  logic [4:0]  d_hi, d_lo;
  int          fails, comparisons;
  bit          ok;

`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin fails++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end

  custom_advance_map_editor #(.DWELL_CYCLES(20)) custom_advance_map_editor_inst (
    .i_clk_sys(clk), .i_arst_n(rst_n),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
    .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
    .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
    .o_rvalid(rvalid), .i_rready(rready), .i_magnet_sw(sw),
    .o_disp_hi(d_hi), .o_disp_lo(d_lo));

  magnet_operator magnet_operator_inst (
    .i_clk_sys(clk), .i_disp_hi(d_hi), .i_disp_lo(d_lo), .o_sw(sw));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // handshakes are judged at the falling edge, where nothing moves
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic ha, hw, hb;
    int   n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    hb = 1'b0;
    n = 0;
    while (!hb && n < 200) begin
      @(negedge clk);
      ha = awvalid & awready;
      hw = wvalid & wready;
      hb = bvalid;
      r = bresp;
      @(posedge clk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    // let an edge pass so a following call never re-raises bready at once
    @(posedge clk);
    `CHK("write answer", 1'b1, hb)
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    logic ha, hr;
    int   n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    hr = 1'b0;
    n = 0;
    while (!hr && n < 200) begin
      @(negedge clk);
      ha = arvalid & arready;
      hr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ha) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    @(posedge clk);
    `CHK("read answer", 1'b1, hr)
  endtask

  task automatic op(input logic [4:0] h, l, input bit a);
    magnet_operator_inst.pick(h, l, a, ok);
    ok_b = ok;
    `CHK("item shown", 1'b1, ok_b)
  endtask

  // one full pass: enter, pick map, cut playback, pick item, its digits
  task automatic edit(input logic [4:0] slot, ph, pl, tn, un, hn,
                      input bit spd);
    wr(REG_CTRL, 32'h0000_0001, rs);
    `CHK("ctrl resp", RESP_OKAY, rs)
    op(CH_BIG_C, CH_SMALL_C, 0);
    op(5'h01, slot, 1);
    op(5'h02, 5'h05, 1);
    op(CH_I, CH_I, 0);
    op(ph, pl, 1);
    op(5'h00, tn, 1);
    op(5'h01, un, 1);
    if (spd) begin
      op(5'h02, hn, 1);
    end
    repeat (20) @(posedge clk);
    rd_reg(REG_STATUS, rd, rs);
    `CHK("state idle", 4'h0, rd[3:0])
  endtask

  task automatic commit_chk(input int w, input logic [8:0] e);
    wr(REG_SELECT, 32'h0000_000C, rs);
    `CHK("select resp", RESP_OKAY, rs)
    repeat (30) @(posedge clk);
    rd_reg(REG_SELECT, rd, rs);
    `CHK("select", 4'hC, rd[3:0])
    rd_reg(8'(REG_RUN_BASE + 4 * w), rd, rs);
    `CHK("run word", e, rd[8:0])
  endtask

  task automatic finish_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #400000;
    fails++;
    $display("watchdog expired");
    finish_test();
  end

  initial begin
    {rst_n, awaddr, araddr, wdata, awvalid, wvalid} = '0;
    {bready, arvalid, rready} = '0;
    wstrb = 4'hF;
    fails = 0;
    comparisons = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      rd_reg(8'(REG_RUN_BASE + 4 * i), rd, rs);
      `CHK("reset word", INIT_WORD[i], rd[8:0])
    end
    rd_reg(8'h0C, rd, rs);
    `CHK("unmapped read", RESP_DECERR, rs)
    wr(REG_STATUS, 32'h0000_0001, rs);
    `CHK("read-only write", RESP_DECERR, rs)
    $display("test reset values done");
    edit(5'h02, CH_W, 5'h00, 5'h01, 5'h03, 5'h00, 1'b0);
    `CHK("accepted", 2'h1, rd[9:8])
    rd_reg(REG_RUN_BASE + 8'h04, rd, rs);
    `CHK("run before commit", 9'h019, rd[8:0])
    commit_chk(1, 9'h00D);
    $display("test angle entry done");
    // 21500 rpm sits between its neighbours, so n2 takes it
    edit(5'h02, CH_N, 5'h02, 5'h02, 5'h01, 5'h05, 1'b1);
    `CHK("speed accepted", 2'h1, rd[9:8])
    commit_chk(4, 9'h0D7);
    $display("test speed entry done");
    // 39 degrees sits on the limit and must be dropped
    edit(5'h02, CH_W, 5'h03, 5'h03, 5'h09, 5'h00, 1'b0);
    `CHK("rejected", 2'h2, rd[9:8])
    commit_chk(7, 9'h019);
    $display("test angle limit done");
    wr(REG_CTRL, 32'h0000_0002, rs);
    `CHK("reload resp", RESP_OKAY, rs)
    commit_chk(4, INIT_WORD[4]);
    $display("test factory reload done");
    finish_test();
  end
endmodule
